//--- rtl/wdt_pkg.sv
// Types shared by the watchdog design.
// Assumes wdt_regs.svh supplies the numeric constants.
package wdt_pkg;
  typedef enum logic [2:0] {
    LK_LOCKED,
    LK_GOT_FIRST,
    LK_WANT_UPPER,
    LK_WANT_MIDDLE,
    LK_WANT_LOW
  } lock_e;

  typedef struct packed {
    logic        running;
    logic [23:0] count;
    logic [23:0] reload;
    lock_e       lock;
    logic        wdt_flag;
    logic        stop_flag;
    logic        irq;
    logic        sys_rst;
    logic        smr;
    logic        tick_q;
    logic [31:0] rdata;
    logic        rvalid;
  } wdt_state_s;
endpackage

//--- rtl/wdt_regs.svh
// Register map, reset values and fixed codes of the reloadable watchdog.
// Assumes an Avalon-MM byte-addressed word bus with 32-bit data.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
`define WDT_ADDR_W        4
`define WDT_CTL_OFS       4'h0
`define WDT_UPPER_OFS     4'h4
`define WDT_MIDDLE_OFS    4'h8
`define WDT_LOW_OFS       4'hc
`define WDT_UNLOCK_FIRST  8'h55
`define WDT_UNLOCK_SECOND 8'haa
`define WDT_RELOAD_RST    24'h000400
`define WDT_COUNT_MAX     24'hffffff
`define WDT_NO_REFRESH    24'h000002
`define WDT_COUNT_ZERO    24'h000000
`define WDT_COUNT_ONE     24'h000001
`define WDT_STAT_WDT_BIT  0
`define WDT_STAT_STOP_BIT 1
`define WDT_STAT_ON_BIT   2
`define WDT_STAT_LOCK_BIT 3
`define WDT_OSC_HZ        10000
`endif

//--- rtl/wdt_top.sv
// Reloadable 24-bit watchdog with unlock-protected reload bytes and Avalon-MM slave.
// Assumes i_osc_tick is a one-cycle pulse per watchdog oscillator period, synchronous to i_mclk.
// Notes on behaviour
// [RULE1] 24-bit down-counter advanced only by oscillator ticks
// [RULE2] Enabled by refresh instruction or always-on option
// [RULE3] Once enabled it never stops counting
// [RULE4] Reload is upper, middle, low bytes concatenated
// [RULE5] Time-out ms equals reload over ten
// [RULE6] Refresh ignored when count two or lower
// [RULE7] Software never programs reload below four
// [RULE8] First enable loads counter from reload
// [RULE9] Each refresh reloads counter, counting continues
// [RULE10] Zero count times out; option picks response
// [RULE11] Interrupt mode raises request, sets status flag
// [RULE12] After interrupt time-out counter restarts at maximum
// [RULE13] Status read clears time-out flag, blocks repeat
// [RULE14] Stopped interrupt mode: recovery, request, both flags
// [RULE15] Reset mode forces system reset, sets flag
// [RULE16] Stopped reset mode: recovery, both flags
// [RULE17] Unlock only after writes 55 then AA
// [RULE18] Unlock writes change no stored control bits
// [RULE19] Software writes upper, middle, low in order
// [RULE20] Any stray write relocks the sequence; writes with byteenable[0] low are ignored and do not relock
// [RULE21] Debugger must keep refreshing during debug
// [RULE22] Byte reads return live counter bytes
// [RULE23] Low byte write completes and relocks
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned OSC_HZ = `WDT_OSC_HZ
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rstn,
  input  wire logic [`WDT_ADDR_W-1:0] i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic      [31:0]            o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire logic                   i_osc_tick,
  input  wire logic                   i_refresh,
  input  wire logic                   i_always_on_option,
  input  wire logic                   i_timeout_response_option,
  input  wire logic                   i_stop_mode,
  output logic                        o_irq,
  output logic                        o_sys_reset,
  output logic                        o_stop_recovery,
  output logic                        o_running
);

  wdt_state_s st;
  wdt_state_s next_st;

  logic wr_ctl;
  logic wr_upper;
  logic wr_middle;
  logic wr_low;
  logic rd_ctl;
  logic any_wr;
  logic timeout;
  logic refresh_ok;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [`WDT_ADDR_W-1:0] a, input logic [`WDT_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // One-cycle accept: wait one cycle, answer on the second
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st.rvalid;
  assign o_avs_readdata    = st.rdata;
  assign o_irq             = st.irq;
  assign o_sys_reset       = st.sys_rst;
  assign o_stop_recovery   = st.smr;
  assign o_running         = st.running;

  always_comb begin
    next_st = st;
    wbyte   = i_avs_writedata[7:0];
    any_wr  = i_avs_write & st.rvalid & i_avs_byteenable[0];
    wr_ctl    = any_wr & hit(i_avs_address, `WDT_CTL_OFS);
    wr_upper  = any_wr & hit(i_avs_address, `WDT_UPPER_OFS);
    wr_middle = any_wr & hit(i_avs_address, `WDT_MIDDLE_OFS);
    wr_low    = any_wr & hit(i_avs_address, `WDT_LOW_OFS);
    rd_ctl    = i_avs_read & st.rvalid & hit(i_avs_address, `WDT_CTL_OFS);
    refresh_ok = i_refresh & (st.count > `WDT_NO_REFRESH); // [RULE6]
    timeout    = st.running & i_osc_tick & (st.count == `WDT_COUNT_ONE); // [RULE10]
    next_st.tick_q = i_osc_tick;

    // Bus handshake: rvalid marks the answer cycle
    next_st.rvalid = (i_avs_read | i_avs_write) & ~st.rvalid;
    next_st.rdata  = 32'h0;
    if (i_avs_read & ~st.rvalid) begin
      unique case (i_avs_address)
        `WDT_CTL_OFS: begin
          next_st.rdata[`WDT_STAT_WDT_BIT]  = st.wdt_flag;
          next_st.rdata[`WDT_STAT_STOP_BIT] = st.stop_flag;
          next_st.rdata[`WDT_STAT_ON_BIT]   = st.running;
          next_st.rdata[`WDT_STAT_LOCK_BIT] = (st.lock == LK_LOCKED);
        end
        `WDT_UPPER_OFS:  next_st.rdata[7:0] = st.count[23:16]; // [RULE22]
        `WDT_MIDDLE_OFS: next_st.rdata[7:0] = st.count[15:8]; // [RULE22]
        `WDT_LOW_OFS:    next_st.rdata[7:0] = st.count[7:0]; // [RULE22]
        default:         next_st.rdata = 32'h0;
      endcase
    end

    // Unlock and ordered reload writes; control writes store nothing
    if (any_wr) begin
      next_st.lock = LK_LOCKED; // [RULE20] [RULE18]
      unique case (st.lock)
        LK_LOCKED:    if (wr_ctl && wbyte == `WDT_UNLOCK_FIRST) next_st.lock = LK_GOT_FIRST; // [RULE17]
        LK_GOT_FIRST: if (wr_ctl && wbyte == `WDT_UNLOCK_SECOND) next_st.lock = LK_WANT_UPPER; // [RULE17]
        LK_WANT_UPPER: if (wr_upper) begin
          next_st.reload[23:16] = wbyte; // [RULE4]
          next_st.lock          = LK_WANT_MIDDLE;
        end
        LK_WANT_MIDDLE: if (wr_middle) begin
          next_st.reload[15:8] = wbyte; // [RULE4]
          next_st.lock         = LK_WANT_LOW;
        end
        LK_WANT_LOW: if (wr_low) begin
          next_st.reload[7:0] = wbyte; // [RULE4]
          next_st.lock        = LK_LOCKED; // [RULE23]
        end
      endcase
    end

    // Counter: enable, refresh, countdown, time-out
    next_st.irq     = 1'b0;
    next_st.sys_rst = 1'b0;
    next_st.smr     = 1'b0;
    if (!st.running) begin
      if (i_refresh | i_always_on_option) begin // [RULE2]
        next_st.running = 1'b1; // [RULE3]
        next_st.count   = st.reload; // [RULE8]
      end
    end else if (refresh_ok) begin
      next_st.count = st.reload; // [RULE9]
    end else if (timeout) begin
      next_st.wdt_flag = 1'b1; // [RULE11] [RULE15]
      next_st.count    = `WDT_COUNT_MAX; // [RULE12]
      if (i_stop_mode) begin
        next_st.stop_flag = 1'b1; // [RULE14] [RULE16]
        next_st.smr       = 1'b1; // [RULE14] [RULE16]
        next_st.irq       = ~i_timeout_response_option; // [RULE14]
      end else if (i_timeout_response_option) begin
        next_st.sys_rst = 1'b1; // [RULE15]
      end else begin
        next_st.irq = 1'b1; // [RULE11]
      end
    end else if (i_osc_tick && st.count != `WDT_COUNT_ZERO) begin
      next_st.count = st.count - `WDT_COUNT_ONE; // [RULE1] [RULE5]
    end

    // Status read clears flags unless a time-out sets them in the same cycle
    if (rd_ctl && !timeout) begin
      next_st.wdt_flag  = 1'b0; // [RULE13]
      next_st.stop_flag = 1'b0; // [RULE13]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st           <= '0;
      st.lock      <= LK_LOCKED;
      st.reload    <= `WDT_RELOAD_RST;
    end else begin
      st <= next_st;
    end
  end

endmodule // wdt_top

//--- verification/watchdog_timer_unlock_reload_test.sv
// Self-checking bench: bus, unlock, refresh and time-outs against a model
// Assumes the rtl header and package are compiled first
`timescale 1ns/1ps
`include "wdt_regs.svh"
module watchdog_timer_unlock_reload_test;
  logic        i_mclk = 0, i_rstn = 0, rd = 0, wr = 0, tick = 0, refr = 0, ao = 0, opt = 0, stp = 0, clr = 0;
  logic [3:0]  adr = '0;
  logic [31:0] wd = '0, q, rdat;
  logic        wreq, irq, srst, smr, run, pend;
  int          err_count = 0, n_compared = 0, seed = 32'h356e, cyc = 0, rl, cnt, fl, rn, m, k;
  wdt_top dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_osc_tick(tick), .i_refresh(refr), .i_always_on_option(ao), .i_timeout_response_option(opt),
    .i_stop_mode(stp), .o_irq(irq), .o_sys_reset(srst), .o_stop_recovery(smr), .o_running(run));
  wdt_intc_model intc (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_irq(irq), .i_clear(clr), .o_pending(pend));
  initial forever #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (++cyc == 20000) begin err_count++; print_verdict(); end
  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin err_count++; $display("[FAIL] %0t read %h exp %h", $time, got, exp); end
  endtask
  task automatic cmp_ev(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp) begin err_count++; $display("[FAIL] %0t event %b exp %b", $time, got, exp); end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    rd <= !w; wr <= w; adr <= a; wd <= {24'($random(seed)), d};
    @(posedge i_mclk iff wreq === 1'b0);
    q = rdat;
    rd <= 0; wr <= 0;
  endtask
  task automatic rdc(); // Status read clears the flags
    acc(0, `WDT_CTL_OFS, 0);
    cmp_rd(q, 32'(8 + 4 * rn + fl));
    fl = 0;
  endtask
  task automatic rc();
    acc(0, `WDT_UPPER_OFS, 0); cmp_rd(q, 32'((cnt >> 16) & 255));
    acc(0, `WDT_LOW_OFS, 0); cmp_rd(q, 32'(cnt & 255));
  endtask
  task automatic ld(input logic [23:0] v); // Software keeps unlock order
    acc(1, 0, `WDT_UNLOCK_FIRST); acc(1, 0, `WDT_UNLOCK_SECOND);
    acc(1, 4, v[23:16]); acc(1, 8, v[15:8]); acc(1, 'hc, v[7:0]);
    rl = v;
  endtask
  task automatic rf(); // One refresh pulse: enables, or reloads when count above two
    @(posedge i_mclk) refr <= 1;
    @(posedge i_mclk) refr <= 0;
    if (!rn || cnt > 2) cnt = rl;
    rn = 1;
  endtask
  task automatic tk();
    @(posedge i_mclk) tick <= 1;
    @(posedge i_mclk) tick <= 0;
    #1 m = (rn && cnt == 1);
    cmp_ev({irq, srst, smr}, m ? {!opt, opt && !stp, stp} : 3'b0);
    if (m) begin cnt = `WDT_COUNT_MAX; fl |= 1 + 2 * stp; end
    else if (rn) cnt--;
  endtask
  initial begin
    rn = 0; cnt = 0; fl = 0; rl = 'h400;
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1;
    rdc();
    ld(24'(5 + ($random(seed) & 3)));
    rdc();
    acc(1, 0, 'h55); acc(1, 0, 'haa); acc(1, 0, 'h00); acc(1, 'hc, 'h01);
    rf(); rc();
    tk(); rf(); rc();
    repeat (rl - 2) tk();
    rf(); rc();
    tk(); tk(); rc();
    cmp_ev({pend, 2'b0}, 3'b100);
    rdc(); rdc();
    @(posedge i_mclk) clr <= 1;
    @(posedge i_mclk) clr <= 0;
    for (k = 1; k < 4; k++) begin opt <= k[0]; stp <= k[1]; rf(); repeat (rl) tk(); rdc(); end
    acc(0, 4'h2, 0); cmp_rd(q, 32'h0);
    i_rstn <= 0; ao <= 1;
    repeat (2) @(posedge i_mclk) i_rstn <= 1;
    repeat (2) @(posedge i_mclk);
    cmp_ev({run, 2'b0}, 3'b100);
    print_verdict();
  end
endmodule // watchdog_timer_unlock_reload_test

//--- verification/wdt_intc_model.sv
// Interrupt controller stand-in: latches watchdog requests until cleared
// Assumes the bench clears pending only after reading the status register
`timescale 1ns/1ps
module wdt_intc_model (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_irq,
  input  wire logic i_clear,
  output logic      o_pending
);
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn) o_pending <= 1'b0;
    else o_pending <= i_irq | (o_pending & ~i_clear);
endmodule // wdt_intc_model

//--- verification/wdt_monitor.sv
// Checker on the watchdog top ports
// Assumes binding into wdt_top; one clock domain
`timescale 1ns/1ps
module wdt_monitor (
  input wire logic i_mclk, i_rstn, i_avs_read, o_avs_waitrequest, i_osc_tick, i_refresh,
  input wire logic i_always_on_option, i_timeout_response_option, i_stop_mode,
  input wire logic o_irq, o_sys_reset, o_stop_recovery, o_running
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  AST_WAIT: assert property (i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("bus stall");
  AST_TICK: assert property (o_irq |-> $past(i_osc_tick)) else $error("irq without tick");
  AST_IRQ: assert property (o_irq |-> !$past(i_timeout_response_option)) else $error("irq in reset mode");
  AST_RST: assert property (o_sys_reset |-> $past(i_timeout_response_option && !i_stop_mode)) else $error("bad reset");
  AST_SMR: assert property (o_stop_recovery |-> $past(i_stop_mode && i_osc_tick)) else $error("bad recovery");
  AST_SIRQ: assert property (o_stop_recovery && !$past(i_timeout_response_option) |-> o_irq) else $error("no irq");
  AST_AO: assert property (i_always_on_option |=> o_running) else $error("always-on idle");
  AST_REF: assert property (i_refresh |=> o_running) else $error("refresh idle");
  AST_ON: assert property (o_running |=> o_running) else $error("stopped");
  AST_PULSE: assert property (o_irq |=> !o_irq) else $error("irq too long");
endmodule // wdt_monitor
bind wdt_top wdt_monitor mon (.*);
